// [urtc_usb_resume_toggle_ctrl.sv]
// Purpose: usb control/status and toggle control subregisters behind a
//          subaddress/subdata register pair, with bus j/k drive, pull-up
//          control and a start-of-frame watchdog timer
// Assumes: all inputs come from logic on i_clk; i_rst synchronous
// Notes:   read data tracks the selected subregister one clock behind
`timescale 1ns/1ps
`default_nettype none

`include "urtc_defines.svh"

// Notes on behaviour
// - subaddress 56h maps the control/status register through subdata.
// - subaddress 57h maps the toggle control register through subdata.
// - wake flag sets on device-initiated resume; writing one clears it unless a resume comes in the same cycle.
// - watchdog enable runs a frame timer making start-of-frame ticks.
// - disconnect bit resets to one; one disconnects pull-up, zero connects.
// - force-j bit drives j on the bus unless the resume bit is set; set only during suspend.
// - resume bit drives k on the bus; zero drives no resume.
// - toggle status bit is read-only, shows selected endpoint toggle.
// - writing one to set command makes toggle one unless clear is written in the same byte; reads as zero.
// - writing one to clear command makes toggle zero; reads as zero.
// - direction bit zero picks out endpoint, one picks in endpoint.
module urtc_usb_resume_toggle_ctrl
  import urtc_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = `URTC_FRAME_NS / `URTC_CLK_NS
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_sa_wr,       // write subaddress selector
  input  wire logic       i_sd_wr,       // write selected subregister
  input  wire logic [7:0] i_wdata,       // write data for either
  input  wire logic       i_resume_done, // resumed by remote wake-up
  input  wire logic       i_sof_rx,      // host start-of-frame seen
  input  wire logic       i_tog_flip,    // packet engine flips a toggle
  input  wire logic       i_tog_dir,
  input  wire logic [1:0] i_tog_ep,
  output logic      [7:0] o_subaddr_q,   // subaddress selector readback
  output logic      [7:0] o_rdata_q,     // subdata readback
  output logic            o_pullup_en_q, // internal pull-up connected
  output logic            o_dp_q,        // d+ drive level
  output logic            o_dm_q,        // d- drive level
  output logic            o_bus_oe_n_q,  // low while driving d+/d-
  output logic            o_sof_tick_q   // start-of-frame event pulse
);

  localparam int unsigned CW = $clog2(FRAME_CYCLES + 1);
  localparam logic [CW-1:0] WD_LAST = CW'(FRAME_CYCLES - 1);
  localparam logic [7:0]    CS_RST  = `URTC_CS_RST; // bit-selectable copy
  urtc_tog_if tog ();

  logic       wake_q;
  logic       wdog_q;
  logic       disc_q;
  logic       fj_q;
  logic       rs_q;
  logic       dir_q;
  urtc_ep_t   ep_q;
  logic [7:0] sa_q;
  logic [CW-1:0] wd_cnt_q;
  logic       wd_fire;
  logic       cs_wr;
  logic       tg_wr;
  logic [7:0] cs_rd;
  logic [7:0] tg_rd;
  logic [7:0] rdata_d;
  urtc_line_t line_d;

  ////////////////////////////////////////////////////////////////////////////
  // subaddress selector and subregister write decode
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sa_q <= `URTC_SA_RST;
    end else if (i_sa_wr) begin
      sa_q <= i_wdata;
    end
  end

  // a subdata write goes to whatever the selector held before this edge
  assign cs_wr = i_sd_wr && (sa_q == `URTC_SA_CS);
  assign tg_wr = i_sd_wr && (sa_q == `URTC_SA_TOG);

  ////////////////////////////////////////////////////////////////////////////
  // control/status: plain read/write control bits
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wdog_q <= CS_RST[`URTC_CS_WDOG];
      disc_q <= CS_RST[`URTC_CS_DISC];
      fj_q   <= CS_RST[`URTC_CS_FJ];
      rs_q   <= CS_RST[`URTC_CS_RS];
    end else if (cs_wr) begin
      wdog_q <= i_wdata[`URTC_CS_WDOG];
      disc_q <= i_wdata[`URTC_CS_DISC];
      fj_q   <= i_wdata[`URTC_CS_FJ];
      rs_q   <= i_wdata[`URTC_CS_RS];
    end
  end

  // wake flag: a resume in the clearing cycle must not be lost, so set wins
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wake_q <= CS_RST[`URTC_CS_WAKE];
    end else if (i_resume_done) begin
      wake_q <= 1'b1;
    end else if (cs_wr && i_wdata[`URTC_CS_WAKE]) begin
      wake_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // toggle control: stored select fields
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dir_q <= 1'b0;
      ep_q  <= '0;
    end else if (tg_wr) begin
      dir_q <= i_wdata[`URTC_TG_DIR];
      ep_q  <= i_wdata[`URTC_TG_EP_HI:`URTC_TG_EP_LO];
    end
  end

  // commands act on the select written in the same byte; with software
  // programming the select first, that equals the stored select anyway
  assign tog.cmd_set = tg_wr && i_wdata[`URTC_TG_SET];
  assign tog.cmd_clr = tg_wr && i_wdata[`URTC_TG_CLR];
  assign tog.cmd_dir = i_wdata[`URTC_TG_DIR];
  assign tog.cmd_ep  = i_wdata[`URTC_TG_EP_HI:`URTC_TG_EP_LO];
  assign tog.rd_dir  = dir_q;
  assign tog.rd_ep   = ep_q;
  assign tog.hw_flip = i_tog_flip;
  assign tog.hw_dir  = i_tog_dir;
  assign tog.hw_ep   = i_tog_ep;

  urtc_toggle_bank #(
    .NUM_EP (`URTC_NUM_EP)
  ) u_bank (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .tog   (tog.bank)
  );

  ////////////////////////////////////////////////////////////////////////////
  // readback images; reserved bits and command bits read as zero
  always_comb begin
    cs_rd                 = `URTC_ZERO8;
    cs_rd[`URTC_CS_WAKE]  = wake_q;
    cs_rd[`URTC_CS_WDOG]  = wdog_q;
    cs_rd[`URTC_CS_DISC]  = disc_q;
    cs_rd[`URTC_CS_FJ]    = fj_q;
    cs_rd[`URTC_CS_RS]    = rs_q;
  end

  always_comb begin
    tg_rd                = `URTC_ZERO8;
    tg_rd[`URTC_TG_STAT] = tog.rd_toggle;
    tg_rd[`URTC_TG_DIR]  = dir_q;
    tg_rd[`URTC_TG_EP_HI:`URTC_TG_EP_LO] = ep_q;
  end

  // unmapped subaddresses read zero; other subregisters live elsewhere
  always_comb begin
    case (sa_q)
      `URTC_SA_CS:  rdata_d = cs_rd;
      `URTC_SA_TOG: rdata_d = tg_rd;
      default:      rdata_d = `URTC_ZERO8;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata_q   <= `URTC_ZERO8;
      o_subaddr_q <= `URTC_SA_RST;
    end else begin
      o_rdata_q   <= rdata_d;
      o_subaddr_q <= sa_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus line drive: resume k beats force j, since j must end before k
  always_comb begin
    if (rs_q) begin
      line_d = urtc_line_k;
    end else if (fj_q) begin
      line_d = urtc_line_j;
    end else begin
      line_d = urtc_line_idle;
    end
  end

  // full speed: j is d+ high d- low, k the reverse
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_dp_q       <= 1'b1;
      o_dm_q       <= 1'b0;
      o_bus_oe_n_q <= 1'b1;
    end else begin
      case (line_d)
        urtc_line_j: begin
          o_dp_q       <= 1'b1;
          o_dm_q       <= 1'b0;
          o_bus_oe_n_q <= 1'b0;
        end
        urtc_line_k: begin
          o_dp_q       <= 1'b0;
          o_dm_q       <= 1'b1;
          o_bus_oe_n_q <= 1'b0;
        end
        default: begin
          o_dp_q       <= 1'b1;
          o_dm_q       <= 1'b0;
          o_bus_oe_n_q <= 1'b1;
        end
      endcase
    end
  end

  // pull-up follows the disconnect bit, inverted
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pullup_en_q <= ~CS_RST[`URTC_CS_DISC];
    end else begin
      o_pullup_en_q <= ~disc_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame watchdog: restarts on every host frame start, so it only fires
  // when one frame period passes without one
  assign wd_fire = wdog_q && (wd_cnt_q == WD_LAST);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wd_cnt_q <= '0;
    end else if (!wdog_q || i_sof_rx || wd_fire) begin
      wd_cnt_q <= '0;
    end else begin
      wd_cnt_q <= wd_cnt_q + CW'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sof_tick_q <= 1'b0;
    end else begin
      o_sof_tick_q <= i_sof_rx || wd_fire;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_wake_set;
    i_resume_done |=> wake_q ##1 (o_rdata_q[`URTC_CS_WAKE] || $past(!cs_rd[7])
                                  || sa_q != `URTC_SA_CS || $past(i_sa_wr));
  endproperty
  a_wake_set : assert property (p_wake_set)
    else $error("wake flag not set by resume");

  property p_wake_clr;
    cs_wr && i_wdata[`URTC_CS_WAKE] && !i_resume_done |=> !wake_q;
  endproperty
  a_wake_clr : assert property (p_wake_clr)
    else $error("writing one did not clear wake flag");

  property p_wake_keep;
    cs_wr && !i_wdata[`URTC_CS_WAKE] && !i_resume_done |=> $stable(wake_q);
  endproperty
  a_wake_keep : assert property (p_wake_keep)
    else $error("writing zero changed wake flag");

  property p_cs_read;
    (sa_q == `URTC_SA_CS) && !i_sd_wr && !i_sa_wr && !i_resume_done
      |=> o_rdata_q == cs_rd;
  endproperty
  a_cs_read : assert property (p_cs_read)
    else $error("control/status readback wrong");

  sequence s_set_wr;
    tg_wr && i_wdata[`URTC_TG_SET] && !i_wdata[`URTC_TG_CLR] && !i_sa_wr;
  endsequence
  sequence s_quiet;
    !i_sa_wr && !i_sd_wr && !i_tog_flip;
  endsequence
  property p_tog_read;
    s_set_wr ##1 s_quiet |=> o_rdata_q[`URTC_TG_STAT]
                             && !o_rdata_q[`URTC_TG_SET];
  endproperty
  a_tog_read : assert property (p_tog_read)
    else $error("toggle status did not read one after set");

  property p_pullup;
    disc_q |=> !o_pullup_en_q;
  endproperty
  a_pullup : assert property (p_pullup)
    else $error("pull-up connected while disconnect set");

  property p_drive_k;
    rs_q |=> !o_bus_oe_n_q && !o_dp_q && o_dm_q;
  endproperty
  a_drive_k : assert property (p_drive_k)
    else $error("resume set but k not driven");

  property p_drive_j;
    fj_q && !rs_q |=> !o_bus_oe_n_q && o_dp_q && !o_dm_q;
  endproperty
  a_drive_j : assert property (p_drive_j)
    else $error("force j set but j not driven");

  property p_release;
    !fj_q && !rs_q |=> o_bus_oe_n_q;
  endproperty
  a_release : assert property (p_release)
    else $error("bus driven with no signalling bit set");

  property p_wdog_fire;
    wdog_q && (wd_cnt_q == WD_LAST) |=> o_sof_tick_q ##1 (wd_cnt_q == '0
                                        || !$past(wdog_q) || $past(i_sof_rx)
                                        || wd_cnt_q == CW'(1));
  endproperty
  a_wdog_fire : assert property (p_wdog_fire)
    else $error("frame watchdog did not fire at period end");

  property p_wdog_off;
    !wdog_q && !i_sof_rx |=> !o_sof_tick_q;
  endproperty
  a_wdog_off : assert property (p_wdog_off)
    else $error("tick while watchdog disabled and no host frame");

endmodule : urtc_usb_resume_toggle_ctrl

`default_nettype wire

// [urtc_defines.svh]
// Purpose: named offsets, bit positions, reset values and timing figures
//          of the resume and toggle control block
// Assumes: included by bare name from every design file that needs it
// Notes:   definitions only; no logic lives here
`ifndef URTC_DEFINES_SVH
`define URTC_DEFINES_SVH

// subaddress codes that select a subregister behind the subdata port
`define URTC_SA_CS        8'h56
`define URTC_SA_TOG       8'h57
`define URTC_SA_RST       8'h00

// control/status subregister bit positions and reset value
`define URTC_CS_WAKE      7
`define URTC_CS_WDOG      5
`define URTC_CS_DISC      3
`define URTC_CS_FJ        1
`define URTC_CS_RS        0
`define URTC_CS_RST       8'h08

// toggle control subregister bit positions
`define URTC_TG_STAT      7
`define URTC_TG_SET       6
`define URTC_TG_CLR       5
`define URTC_TG_DIR       4
`define URTC_TG_EP_HI     1
`define URTC_TG_EP_LO     0

// generic values
`define URTC_ZERO8        8'h00
`define URTC_NUM_EP       4

// frame timer: nominal full-speed frame and the system clock period
`define URTC_FRAME_NS     1000000
`define URTC_CLK_NS       10

`endif

// [urtc_pkg.sv]
// Purpose: shared types of the resume and toggle control block
// Assumes: nothing beyond the language
// Notes:   numbers live in urtc_defines.svh, types live here
package urtc_pkg;

  // what the block drives onto the bus data lines
  typedef enum logic [1:0] {
    urtc_line_idle = 2'b00,
    urtc_line_j    = 2'b01,
    urtc_line_k    = 2'b10
  } urtc_line_t;

  // endpoint number 0..3
  typedef logic [1:0] urtc_ep_t;

endpackage : urtc_pkg

// [urtc_tog_if.sv]
// Purpose: carrier between the register front end and the toggle bank
// Assumes: all signals live in the single system clock domain
// Notes:   commands are one-cycle pulses, read select is a level
`timescale 1ns/1ps
`default_nettype none

interface urtc_tog_if;
  import urtc_pkg::*;
  logic     cmd_set;   // force selected toggle to one
  logic     cmd_clr;   // force selected toggle to zero
  logic     cmd_dir;   // 0 out, 1 in, for the command
  urtc_ep_t cmd_ep;    // endpoint for the command
  logic     rd_dir;    // direction of the status read
  urtc_ep_t rd_ep;     // endpoint of the status read
  logic     rd_toggle; // current toggle of the read selection
  logic     hw_flip;   // packet engine flips a toggle
  logic     hw_dir;
  urtc_ep_t hw_ep;

  modport ctrl (output cmd_set, cmd_clr, cmd_dir, cmd_ep, rd_dir, rd_ep,
                output hw_flip, hw_dir, hw_ep, input rd_toggle);
  modport bank (input cmd_set, cmd_clr, cmd_dir, cmd_ep, rd_dir, rd_ep,
                input hw_flip, hw_dir, hw_ep, output rd_toggle);
endinterface : urtc_tog_if

`default_nettype wire

// [urtc_toggle_bank.sv]
// Purpose: holds the data toggle of every in and out endpoint
// Assumes: commands and flips arrive as one-cycle pulses on i_clk
// Notes:   a software command beats a packet-engine flip on the same entry
`timescale 1ns/1ps
`default_nettype none

`include "urtc_defines.svh"

module urtc_toggle_bank
  import urtc_pkg::*;
#(
  parameter int unsigned NUM_EP = `URTC_NUM_EP
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  urtc_tog_if.bank  tog
);

  localparam int unsigned NUM_ENT = 2 * NUM_EP;

  logic [NUM_ENT-1:0] tog_q;

  ////////////////////////////////////////////////////////////////////////////
  // one toggle flop per entry; entry index is {direction, endpoint}
  for (genvar i = 0; i < NUM_ENT; i++) begin : g_ent
    logic cmd_hit;
    logic hw_hit;
    assign cmd_hit = (tog.cmd_set | tog.cmd_clr)
                     && ({tog.cmd_dir, tog.cmd_ep} == 3'(i));
    assign hw_hit  = tog.hw_flip && ({tog.hw_dir, tog.hw_ep} == 3'(i));
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        tog_q[i] <= 1'b0;
      end else if (cmd_hit) begin
        // clear wins when both commands come in one write
        tog_q[i] <= tog.cmd_clr ? 1'b0 : 1'b1;
      end else if (hw_hit) begin
        tog_q[i] <= ~tog_q[i];
      end
    end
  end

  // status of the entry picked by the stored select fields
  assign tog.rd_toggle = tog_q[{tog.rd_dir, tog.rd_ep}];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_bank_set;
    tog.cmd_set && !tog.cmd_clr |=> tog_q[$past({tog.cmd_dir, tog.cmd_ep})];
  endproperty
  a_bank_set : assert property (p_bank_set)
    else $error("set command did not give toggle one");

  property p_bank_clr;
    tog.cmd_clr |=> !tog_q[$past({tog.cmd_dir, tog.cmd_ep})];
  endproperty
  a_bank_clr : assert property (p_bank_clr)
    else $error("clear command did not give toggle zero");

endmodule : urtc_toggle_bank

`default_nettype wire

// [urtc_host_model.sv]
// Purpose: usb host model on the far side of the bus pins
// Assumes: one clock; outputs change at the falling edge
// Notes:   reports a finished remote wake-up once per k episode and
//          issues start-of-frame pulses while asked to
`timescale 1ns/1ps
`default_nettype none

module urtc_host_model #(
  parameter int unsigned K_HOLD  = 8,
  parameter int unsigned SOF_GAP = 10
) (
  input  wire logic i_clk,
  input  wire logic i_sof_en,
  input  wire logic i_dp,
  input  wire logic i_dm,
  input  wire logic i_oe_n,
  output logic      o_sof_rx,
  output logic      o_resume_done
);
  int unsigned k_cnt     = 0;
  int unsigned gap_cnt   = 0;
  logic        done_seen = 1'b0;
  logic        sof_q     = 1'b0;
  logic        done_q    = 1'b0;

  assign o_sof_rx      = sof_q;
  assign o_resume_done = done_q;

  //////////////////////////////////////////////////////////////////////////
  // k must stand a while before the host counts it, so a glitch never wakes
  always @(negedge i_clk) begin
    done_q <= 1'b0;
    if (!i_oe_n && !i_dp && i_dm) begin
      k_cnt <= k_cnt + 1;
      if (k_cnt == K_HOLD && !done_seen) begin
        done_q    <= 1'b1;
        done_seen <= 1'b1;
      end
    end else begin
      k_cnt     <= 0;
      done_seen <= 1'b0;
    end
  end

  // frame pulses every SOF_GAP cycles while enabled
  always @(negedge i_clk) begin
    sof_q <= 1'b0;
    if (!i_sof_en) begin
      gap_cnt <= 0;
    end else if (gap_cnt == SOF_GAP - 1) begin
      gap_cnt <= 0;
      sof_q   <= 1'b1;
    end else begin
      gap_cnt <= gap_cnt + 1;
    end
  end
endmodule : urtc_host_model

`default_nettype wire

// [urtc_usb_resume_toggle_ctrl_tb.sv]
// Purpose: self-checking bench of the resume and toggle control block
// Assumes: inputs driven at the falling edge; short frame of 20 cycles
// Notes:   expectations come from the bench functions, never the design
`timescale 1ns/1ps
`default_nettype none

`include "urtc_defines.svh"

module urtc_usb_resume_toggle_ctrl_tb;
  import urtc_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, sa_wr = 1'b0, sd_wr = 1'b0;
  logic [7:0] wdata = 8'h00, subaddr, rdata;
  logic       flip = 1'b0, fdir = 1'b0, sof_en = 1'b0;
  logic [1:0] fep = 2'b00;
  logic       resume_done, sof_rx, pullup_en, dp, dm, oe_n, tick;
  logic       tog [2][4];
  int         err_total = 0;
  int         cmp_count = 0;

  urtc_usb_resume_toggle_ctrl #(.FRAME_CYCLES(20)) DUT (
    .i_clk(clk), .i_rst(rst), .i_sa_wr(sa_wr), .i_sd_wr(sd_wr),
    .i_wdata(wdata), .i_resume_done(resume_done), .i_sof_rx(sof_rx),
    .i_tog_flip(flip), .i_tog_dir(fdir), .i_tog_ep(fep),
    .o_subaddr_q(subaddr), .o_rdata_q(rdata), .o_pullup_en_q(pullup_en),
    .o_dp_q(dp), .o_dm_q(dm), .o_bus_oe_n_q(oe_n), .o_sof_tick_q(tick));

  urtc_host_model u_host (
    .i_clk(clk), .i_sof_en(sof_en), .i_dp(dp), .i_dm(dm), .i_oe_n(oe_n),
    .o_sof_rx(sof_rx), .o_resume_done(resume_done));

  // 100 MHz system clock
  initial begin
    forever #5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  // expected images of the subregisters and the line drive
  function automatic logic [7:0] cs_read(input logic w, input logic [7:0] d);
    return {w, 1'b0, d[5], 1'b0, d[3], 1'b0, d[1:0]};
  endfunction : cs_read

  // k wins over j; neither releases the lines
  function automatic logic [7:0] bus_exp(input logic [7:0] d);
    return d[0] ? 8'h01 : (d[1] ? 8'h02 : 8'h06);
  endfunction : bus_exp

  function automatic logic [7:0] tog_read(input logic t, input logic dr,
                                          input logic [1:0] ep);
    return {t, 2'b00, dr, 2'b00, ep};
  endfunction : tog_read

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one-cycle strobe: sel 0 writes the selector, 1 the subregister
  task automatic wr(input logic sel, input logic [7:0] d);
    @(negedge clk);
    wdata = d;
    sa_wr = ~sel;
    sd_wr = sel;
    @(negedge clk);
    sa_wr = 1'b0;
    sd_wr = 1'b0;
  endtask : wr

  // subdata trails a write by two edges
  task automatic settle;
    repeat (2) @(negedge clk);
  endtask : settle

  //////////////////////////////////////////////////////////////////////////
  initial begin : main
    logic [7:0] tbl [7] = '{8'h00, 8'h02, 8'h00, 8'h01, 8'h00, 8'h80, 8'h08};
    logic       wake, dr, ok;
    logic [1:0] ep, op;
    logic [7:0] d;
    int         n_tick, n_sof;
    void'($urandom(53413));
    foreach (tog[i, j]) tog[i][j] = 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk(subaddr, 8'h00);
    chk(rdata, 8'h00);
    chk({5'h00, oe_n, dp, dm}, 8'h06);
    chk({7'h00, pullup_en}, 8'h00);
    $display("test reset done");

    wr(0, `URTC_SA_CS);
    settle();
    chk(subaddr, 8'h56);
    chk(rdata, 8'h08);
    wake = 1'b0;
    // j, release, then k: the order that software must keep
    foreach (tbl[i]) begin
      wr(1, tbl[i]);
      if (tbl[i][7]) wake = 1'b0;
      if (tbl[i][0]) begin
        ok = 1'b0;
        for (int k = 0; k < 40 && !ok; k++) begin
          @(posedge clk);
          ok = resume_done;
        end
        if (!ok) begin
          err_total++;
          give_verdict();
        end
        wake = 1'b1;
      end
      settle();
      chk(rdata, cs_read(wake, tbl[i]));
      chk({5'h00, oe_n, dp, dm}, bus_exp(tbl[i]));
      chk({7'h00, pullup_en}, {7'h00, ~tbl[i][3]});
    end
    $display("test control status done");

    // watchdog alone: ticks at 21, 41, 61 and 81 cycles
    wr(1, 8'h20);
    n_tick = 0;
    repeat (95) begin
      @(negedge clk);
      n_tick += int'(tick);
    end
    chk(8'(n_tick), 8'h04);
    wr(1, 8'h00);
    n_tick = 0;
    n_sof  = 0;
    sof_en = 1'b1;
    for (int k = 0; k < 80; k++) begin
      @(negedge clk);
      if (k == 60) sof_en = 1'b0;
      n_tick += int'(tick);
      n_sof  += int'(sof_rx);
    end
    chk(8'(n_tick), 8'(n_sof));
    // watchdog on while host frames keep coming: it must stay silent
    wr(1, 8'h20);
    n_tick = 0;
    n_sof  = 0;
    sof_en = 1'b1;
    repeat (60) begin
      @(negedge clk);
      n_tick += int'(tick);
      n_sof  += int'(sof_rx);
    end
    sof_en = 1'b0;
    chk(8'(n_tick), 8'(n_sof));
    wr(1, 8'h00);
    $display("test frame timer done");

    wr(0, `URTC_SA_TOG);
    for (int i = 0; i < 40; i++) begin
      dr = 1'($urandom % 2);
      ep = 2'($urandom % 4);
      op = (i < 4) ? 2'(i) : 2'($urandom % 4);
      d  = {1'b0, op, dr, 2'b00, ep};
      wr(1, d);
      if (op[0]) tog[dr][ep] = 1'b0;
      else if (op[1]) tog[dr][ep] = 1'b1;
      settle();
      chk(rdata, tog_read(tog[dr][ep], dr, ep));
      // packet engine flip on a random entry
      @(negedge clk);
      flip = 1'b1;
      fdir = 1'($urandom % 2);
      fep  = 2'($urandom % 4);
      @(negedge clk);
      flip = 1'b0;
      tog[fdir][fep] = ~tog[fdir][fep];
      settle();
      chk(rdata, tog_read(tog[dr][ep], dr, ep));
    end
    $display("test toggles done");

    wr(0, 8'h58);
    wr(1, 8'hff);
    settle();
    chk(subaddr, 8'h58);
    chk(rdata, 8'h00);
    // the stray write must have left control/status and the lines alone
    wr(0, `URTC_SA_CS);
    settle();
    chk(rdata, 8'h00);
    chk({5'h00, oe_n, dp, dm}, 8'h06);
    $display("test unmapped done");
    give_verdict();
  end : main
endmodule : urtc_usb_resume_toggle_ctrl_tb

`default_nettype wire
